// ==== logic/sps_pkg.sv ====
package sps_pkg;

    localparam int IDX_W = 6;
    localparam int MAG_W = 7;
    localparam int RES_W = 2;

    // distributor position after reset
    localparam logic [5:0] IDX_RESET = 6'h00;

    // step size in sixteenth-step units for the coarsest resolution
    localparam logic [5:0] STEP_COARSE = 6'h10;

    // quarter-wave current table in percent, 16 subdivisions
    localparam logic [6:0] SIN_TBL [0:16] = '{
        7'h00, 7'h0B, 7'h14, 7'h1E, 7'h28, 7'h2F, 7'h38, 7'h3F, 7'h47,
        7'h4D, 7'h53, 7'h58, 7'h5C, 7'h60, 7'h62, 7'h64, 7'h64
    };
    localparam logic [6:0] MAG_FULL = 7'h64;
    localparam logic [6:0] MAG_OFF  = 7'h00;

    // phase drive bit positions
    localparam int DRV_A  = 0;
    localparam int DRV_AB = 1;
    localparam int DRV_B  = 2;
    localparam int DRV_BB = 3;

    localparam logic [1:0] RES_COARSEST = 2'h0;
    localparam logic [1:0] RES_HALF_RISE = 2'h1;

    typedef enum logic [1:0] {
        SPS_FAULT_NONE     = 2'b00,
        SPS_FAULT_OPEN     = 2'b01,
        SPS_FAULT_OVERCUR  = 2'b10,
        SPS_FAULT_OVERHEAT = 2'b11
    } sps_fault_kind_t;

endpackage : sps_pkg

// ==== logic/sps_edge_detect.sv ====
`timescale 1ns/1ps
module sps_edge_detect (
    input  wire logic i_clock,
    input  wire logic i_reset_n,
    input  wire logic i_clear,
    input  wire logic i_level,
    output logic      o_rise,
    output logic      o_fall
);

    typedef struct packed {
        logic prev;
        logic armed;
    } sps_edge_state_t;

    sps_edge_state_t st;
    sps_edge_state_t next_st;

    // tracks the level even when disabled so a change seen while idle
    // never turns into a step on re-enable
    always_comb begin
        next_st       = st;
        next_st.prev  = i_level;
        next_st.armed = 1'b1;
        if (i_clear) begin
            next_st.armed = 1'b0;
        end
    end

    assign o_rise = st.armed & ~i_clear & i_level & ~st.prev;
    assign o_fall = st.armed & ~i_clear & ~i_level & st.prev;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : sps_edge_detect

// ==== logic/sps_sequencer.sv ====
`timescale 1ns/1ps
module sps_sequencer (
    input  wire logic       i_clock,
    input  wire logic       i_reset_n,
    input  wire logic       i_system_reset_low,
    input  wire logic       i_enable,
    input  wire logic       i_step_clock,
    input  wire logic       i_direction_select,
    input  wire logic       i_step_resolution_sel_lo,
    input  wire logic       i_step_resolution_sel_hi,
    input  wire logic       i_clock_edge_sel,
    input  wire logic       i_pwm_off_window,
    input  wire logic       i_flyback_seen,
    input  wire logic       i_current_ge_open_min,
    input  wire logic       i_overcurrent,
    input  wire logic       i_overheat,
    output logic [3:0]      o_phase_drive,
    output logic [6:0]      o_current_a,
    output logic [6:0]      o_current_b,
    output logic            o_excitation_monitor_out,
    output logic            o_fault_flag_out,
    output logic            o_fault_flag_out_oe,
    output logic [1:0]      o_fault_kind_level
);

    typedef struct packed {
        logic [5:0] idx;
        logic [3:0] drv;
        logic [6:0] cur_a;
        logic [6:0] cur_b;
        logic       monitor;
        logic       f_open;
        logic       f_oc;
        logic       f_ot;
        logic [1:0] kind;
    } sps_state_t;

    sps_state_t st;
    sps_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////

    logic       pin_reset;
    logic       step_rise;
    logic       step_fall;
    logic       step_ev;
    logic       faulted;
    logic       open_ev;
    logic [1:0] res;
    logic [2:0] shift;
    logic [5:0] step_size;

    assign pin_reset = ~i_system_reset_low;
    assign res       = {i_step_resolution_sel_hi, i_step_resolution_sel_lo};
    assign shift     = {1'b0, res} + {2'b00, ~i_clock_edge_sel};
    function automatic logic [5:0] step_coarse_shr(input logic [2:0] s);
        return sps_pkg::STEP_COARSE >> s;
    endfunction : step_coarse_shr

    assign step_size = step_coarse_shr(shift);
    assign faulted   = st.f_open | st.f_oc | st.f_ot;

    sps_edge_detect u_step_edge (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_clear   (pin_reset),
        .i_level   (i_step_clock),
        .o_rise    (step_rise),
        .o_fall    (step_fall)
    );

    // frozen while disabled or faulted
    assign step_ev = i_enable & ~faulted & (step_rise | (~i_clock_edge_sel & step_fall));
    // only meaningful above the open-detect current floor
    assign open_ev = i_enable & i_pwm_off_window & i_current_ge_open_min & ~i_flyback_seen;

    ////////////////////////////////////////////////////////////////////////////

    logic [1:0] quad;
    logic [3:0] sub;
    logic [6:0] mag_a;
    logic [6:0] mag_b;
    logic       neg_a;
    logic       neg_b;

    always_comb begin
        next_st = st;
        if (step_ev) begin
            if (i_direction_select) begin
                next_st.idx = st.idx - step_size;
            end else begin
                next_st.idx = st.idx + step_size;
            end
        end
        quad  = next_st.idx[5:4];
        sub   = next_st.idx[3:0];
        neg_a = (quad == 2'h1) || (quad == 2'h2);
        neg_b = quad[1];
        if (quad[0]) begin
            mag_a = sps_pkg::SIN_TBL[sub];
            mag_b = sps_pkg::SIN_TBL[5'h10 - {1'b0, sub}];
        end else begin
            mag_a = sps_pkg::SIN_TBL[5'h10 - {1'b0, sub}];
            mag_b = sps_pkg::SIN_TBL[sub];
        end
        if (i_clock_edge_sel && res == sps_pkg::RES_COARSEST) begin
            // two-phase: both windings full, signs by quadrant
            mag_a = sps_pkg::MAG_FULL;
            mag_b = sps_pkg::MAG_FULL;
        end else if (i_clock_edge_sel && res == sps_pkg::RES_HALF_RISE) begin
            // rising-only half step drops the 71 percent level
            mag_a = (mag_a != sps_pkg::MAG_OFF) ? sps_pkg::MAG_FULL : sps_pkg::MAG_OFF;
            mag_b = (mag_b != sps_pkg::MAG_OFF) ? sps_pkg::MAG_FULL : sps_pkg::MAG_OFF;
        end
        if (i_enable) begin
            next_st.f_open = st.f_open | open_ev;
            next_st.f_oc   = st.f_oc | i_overcurrent;
            next_st.f_ot   = st.f_ot | i_overheat;
        end
        if (next_st.f_ot) begin
            next_st.kind = sps_pkg::SPS_FAULT_OVERHEAT;
        end else if (next_st.f_oc) begin
            next_st.kind = sps_pkg::SPS_FAULT_OVERCUR;
        end else if (next_st.f_open) begin
            next_st.kind = sps_pkg::SPS_FAULT_OPEN;
        end else begin
            next_st.kind = sps_pkg::SPS_FAULT_NONE;
        end
        next_st.monitor = ~next_st.idx[5];
        if (i_enable && !(next_st.f_open | next_st.f_oc | next_st.f_ot)) begin
            next_st.cur_a               = mag_a;
            next_st.cur_b               = mag_b;
            next_st.drv[sps_pkg::DRV_A]  = (mag_a != sps_pkg::MAG_OFF) & ~neg_a;
            next_st.drv[sps_pkg::DRV_AB] = (mag_a != sps_pkg::MAG_OFF) & neg_a;
            next_st.drv[sps_pkg::DRV_B]  = (mag_b != sps_pkg::MAG_OFF) & ~neg_b;
            next_st.drv[sps_pkg::DRV_BB] = (mag_b != sps_pkg::MAG_OFF) & neg_b;
        end else begin
            next_st.cur_a = sps_pkg::MAG_OFF;
            next_st.cur_b = sps_pkg::MAG_OFF;
            next_st.drv   = 4'h0;
        end
        if (pin_reset) begin
            next_st = '0;
            next_st.idx     = sps_pkg::IDX_RESET;
            next_st.monitor = ~sps_pkg::IDX_RESET[5];
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st         <= '0;
            st.monitor <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_phase_drive            = st.drv;
    assign o_current_a              = st.cur_a;
    assign o_current_b              = st.cur_b;
    assign o_excitation_monitor_out = st.monitor;
    assign o_fault_flag_out         = 1'b0;
    assign o_fault_flag_out_oe      = st.f_open | st.f_oc | st.f_ot;
    assign o_fault_kind_level       = st.kind;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    logic run;
    assign run = i_enable & ~faulted & ~pin_reset;

    cw_step_a: assert property (run & step_rise & ~i_direction_select |=>
        st.idx == 6'($past(st.idx) + $past(step_size))) else $error("clockwise step wrong");
    ccw_step_a: assert property (run & step_rise & i_direction_select |=>
        st.idx == 6'($past(st.idx) - $past(step_size))) else $error("counterclockwise step wrong");
    fall_ignore_a: assert property (run & step_fall & i_clock_edge_sel |=> $stable(st.idx))
        else $error("falling edge stepped in rising mode");
    fall_step_a: assert property (run & step_fall & ~i_clock_edge_sel |=> st.idx != $past(st.idx))
        else $error("falling edge did not step");
    enable_off_a: assert property (!i_enable |=> o_phase_drive == 4'h0 && o_current_a == 7'h00)
        else $error("drive on while disabled");
    hold_state_a: assert property (!i_enable & ~pin_reset |=> $stable(st.idx) && $stable(o_fault_kind_level))
        else $error("state moved while disabled");
    pin_reset_a: assert property (pin_reset |=> st.idx == 6'h00 && !o_fault_flag_out_oe
        && o_fault_kind_level == 2'b00) else $error("reset pin did not clear");
    fault_latch_a: assert property (o_fault_flag_out_oe & ~pin_reset |=>
        o_fault_flag_out_oe && o_phase_drive == 4'h0) else $error("fault released without reset");
    open_flag_a: assert property (open_ev & ~pin_reset & ~i_overcurrent & ~i_overheat & ~faulted |=>
        o_fault_flag_out_oe && o_fault_kind_level == 2'b01) else $error("open terminal not flagged");
    heat_kind_a: assert property (i_enable & i_overheat & ~pin_reset |=> o_fault_kind_level == 2'b11)
        else $error("overheat kind wrong");
    // a fault arriving in the same cycle rightly turns the currents off
    full_mode_a: assert property (run & i_clock_edge_sel & res == 2'h0 & ~i_overcurrent & ~i_overheat & ~open_ev |=>
        o_current_a == 7'h64 && o_current_b == 7'h64) else $error("full step current wrong");

    sixteenth_cov: cover property (run & ~i_clock_edge_sel & res == 2'h3 & step_fall);
    fault_cov: cover property (open_ev ##1 o_fault_flag_out_oe);
    wrap_cov: cover property (run & step_ev ##1 st.idx == 6'h00);

endmodule : sps_sequencer

// ==== bench/sps_controller_model.sv ====
`timescale 1ns/1ps
module sps_controller_model (
    input  wire logic i_clock,
    output logic      o_step_clock,
    output logic      o_direction_select,
    output logic      o_step_resolution_sel_lo,
    output logic      o_step_resolution_sel_hi,
    output logic      o_clock_edge_sel,
    output logic      o_system_reset_low,
    output logic      o_enable
);
    initial begin
        o_step_clock             = 1'b0;
        o_direction_select       = 1'b0;
        o_step_resolution_sel_lo = 1'b0;
        o_step_resolution_sel_hi = 1'b0;
        o_clock_edge_sel         = 1'b0;
        o_system_reset_low       = 1'b1;
        o_enable                 = 1'b0;
    end
    //////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_clock);
    endtask : wait_clk
    // one edge, then a full level at the fastest legal rate, never faster
    task automatic toggle();
        o_step_clock = ~o_step_clock;
        wait_clk(o_clock_edge_sel ? 400 : 1000);
    endtask : toggle
    task automatic set_mode(input logic e, input logic h, input logic l);
        o_clock_edge_sel         = e;
        o_step_resolution_sel_hi = h;
        o_step_resolution_sel_lo = l;
        wait_clk(280);
    endtask : set_mode
    task automatic set_dir(input logic d);
        o_direction_select = d;
        wait_clk(280);
    endtask : set_dir
    task automatic set_en(input logic v);
        o_enable = v;
        // no chopping is offered until 30 us after enable rises
        wait_clk(v ? 1200 : 4);
    endtask : set_en
    task automatic pin_reset();
        o_system_reset_low = 1'b0;
        wait_clk(2);
        o_system_reset_low = 1'b1;
        wait_clk(400);
    endtask : pin_reset
endmodule : sps_controller_model

// ==== bench/sps_sequencer_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t %h %h", $time, g, e); end end
module sps_sequencer_test;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       pwm = 1'b0, fly = 1'b1, ge = 1'b1, oc = 1'b0, oh = 1'b0;
    wire logic  stp, dir, lo, hi, esel, srl, en;
    logic [3:0] drv;
    logic [6:0] cur_a, cur_b;
    logic       mon, ff, ff_oe;
    logic [1:0] kind;
    int         mismatches = 0, cmp_count = 0, idx = 0;
    bit         faulted = 1'b0;
    integer     seed = 32'h74f90531;
    // {overheat, overcurrent, pwm off window, no flyback}
    // last case is an open pattern below the open-detect current floor
    logic [3:0] cases [5] = '{4'h3, 4'h4, 4'h8, 4'hC, 4'h3};
    logic [1:0] kinds [5] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
    always #12.5 clk = ~clk;
    sps_controller_model ctl (.i_clock(clk), .o_step_clock(stp), .o_direction_select(dir),
        .o_step_resolution_sel_lo(lo), .o_step_resolution_sel_hi(hi), .o_clock_edge_sel(esel),
        .o_system_reset_low(srl), .o_enable(en));
    sps_sequencer dut (.i_clock(clk), .i_reset_n(rst_n), .i_system_reset_low(srl), .i_enable(en),
        .i_step_clock(stp), .i_direction_select(dir), .i_step_resolution_sel_lo(lo),
        .i_step_resolution_sel_hi(hi), .i_clock_edge_sel(esel), .i_pwm_off_window(pwm),
        .i_flyback_seen(fly), .i_current_ge_open_min(ge), .i_overcurrent(oc), .i_overheat(oh),
        .o_phase_drive(drv), .o_current_a(cur_a), .o_current_b(cur_b), .o_excitation_monitor_out(mon),
        .o_fault_flag_out(ff), .o_fault_flag_out_oe(ff_oe), .o_fault_kind_level(kind));
    //////////////////////////////////////////////////////////////////
    function automatic logic [17:0] exp_cur(input int p, input bit e, input int code);
        int         r;
        int         q;
        logic [6:0] a;
        logic [6:0] b;
        r = p % 16;
        q = (p / 16) % 4;
        a = (q % 2 == 0) ? sps_pkg::SIN_TBL[16 - r] : sps_pkg::SIN_TBL[r];
        b = (q % 2 == 0) ? sps_pkg::SIN_TBL[r] : sps_pkg::SIN_TBL[16 - r];
        // rising-only full and half steps drive whole current
        if (e && code < 2) begin
            if (code == 0 || a != 7'h00) a = sps_pkg::MAG_FULL;
            if (code == 0 || b != 7'h00) b = sps_pkg::MAG_FULL;
        end
        // winding a follows cosine, winding b follows sine
        return {b != 7'h00 && q >= 2, b != 7'h00 && q < 2, a != 7'h00 && (q == 1 || q == 2),
                a != 7'h00 && (q == 0 || q == 3), a, b};
    endfunction : exp_cur
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic chk_pos();
        `CHK(mon, !idx[5])
        if (en && !faulted) `CHK({drv, cur_a, cur_b}, exp_cur(idx, esel, 2 * hi + lo))
    endtask : chk_pos
    task automatic edge_once();
        ctl.toggle();
        if (en && !faulted && (stp || !esel))
            idx = (idx + 64 + (dir ? -1 : 1) * (16 >> (2 * hi + lo + !esel))) % 64;
        chk_pos();
    endtask : edge_once
    //////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        `CHK(mon, 1'b1)
        `CHK({drv, ff_oe, kind}, 7'h00)
        ctl.wait_clk(400);
        ctl.set_en(1'b1);
        ctl.set_mode(1'b0, 1'b1, 1'b1);
        chk_pos();
        $display("test reset done");
        repeat (33) edge_once();
        repeat (8) begin
            ctl.set_dir(1'($random(seed)));
            edge_once();
        end
        $display("test sweep done");
        for (int m = 0; m < 8; m++) begin
            ctl.set_mode(m[2], m[1], m[0]);
            repeat (4) edge_once();
            ctl.set_mode(1'b0, 1'b1, 1'b1);
            chk_pos();
        end
        $display("test modes done");
        ctl.set_en(1'b0);
        `CHK({drv, cur_a, cur_b}, 18'h0)
        oh = 1'b1;
        edge_once();
        edge_once();
        oh = 1'b0;
        ctl.set_en(1'b1);
        `CHK(ff_oe, 1'b0)
        chk_pos();
        $display("test enable done");
        for (int k = 0; k < 5; k++) begin
            ge = k != 4;
            {oh, oc, pwm, fly} = cases[k] ^ 4'h1;
            ctl.wait_clk(3);
            `CHK({ff_oe, kind}, {kinds[k] != 2'h0, kinds[k]})
            faulted = kinds[k] != 2'h0;
            if (faulted) `CHK(drv, 4'h0)
            {oh, oc, pwm, fly} = 4'h1;
            ge = 1'b1;
            edge_once();
            `CHK(kind, kinds[k])
            `CHK(ff, 1'b0)
            ctl.pin_reset();
            idx = 0;
            faulted = 1'b0;
            `CHK({ff_oe, kind}, 3'h0)
            chk_pos();
        end
        $display("test faults done");
        give_verdict();
    end
    // the tests need about 82k cycles
    initial begin
        repeat (120000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
endmodule : sps_sequencer_test
